// ### hw/imras_pkg.sv
// =====================================================================
// Shared constants and carriers for the receive/ack/stop sequencer
package imras_pkg;

  // ===================================================================
  // Control register two bit positions
  localparam int CTRL2_STOP_EN_BIT = 2;
  localparam int CTRL2_RCV_EN_BIT  = 3;
  localparam int CTRL2_ACK_EN_BIT  = 4;
  localparam int CTRL2_W           = 8;

  // ===================================================================
  // Status register bit positions
  localparam int STAT_BUF_FULL_BIT = 0;
  localparam int STAT_STOP_DET_BIT = 4;
  localparam int STAT_W            = 8;

  // ===================================================================
  // Data and baud widths
  localparam int BYTE_W            = 8;
  localparam int BAUD_REG_W        = 8;
  localparam int BAUD_FIELD_W      = 7;
  localparam int BIT_CNT_W         = 4;

  // Last bit index of a byte, counted from zero
  localparam logic [BIT_CNT_W-1:0] LAST_BIT_IDX = 4'h7;

  // ===================================================================
  // Reset values
  localparam logic [BYTE_W-1:0]    RST_BYTE    = 8'h00;
  localparam logic [BIT_CNT_W-1:0] RST_BIT_CNT = 4'h0;

  // ===================================================================
  // Sequencer states, one-hot
  typedef enum logic [10:0] {
    S_IDLE     = 11'h001,
    S_RX_LOW   = 11'h002,
    S_RX_HIGH  = 11'h004,
    S_ACK_LOW  = 11'h008,
    S_ACK_WAIT = 11'h010,
    S_ACK_HIGH = 11'h020,
    S_STP_SDA  = 11'h040,
    S_STP_LOW  = 11'h080,
    S_STP_SCLH = 11'h100,
    S_STP_DET  = 11'h200,
    S_STP_END  = 11'h400
  } imras_fsm_type;

  // ===================================================================
  // Software command strobes for the control register two bits
  typedef struct packed {
    logic rcv_set;
    logic ack_set;
    logic stop_set;
    logic ack_data;
  } imras_cmd_type;

  // Software access strobes for buffer and flags
  typedef struct packed {
    logic buf_wr;
    logic buf_rd;
    logic write_collision_flag_clr;
    logic ovf_clr;
    logic irq_clr;
  } imras_sw_type;

  // Status flags
  typedef struct packed {
    logic buffer_full;
    logic receive_overflow;
    logic write_collision;
    logic serial_irq;
    logic stop_detected;
  } imras_flags_type;

endpackage

// ### hw/imras_brg.sv
`timescale 1ns/1ps
// =====================================================================
// Baud rate generator: reloadable down counter with rollover tick
module imras_brg #(
  parameter int BAUD_W = 7
) (
  input  wire logic              i_clk,
  input  wire logic              i_reset,
  input  wire logic              i_load,
  input  wire logic              i_run,
  input  wire logic [BAUD_W-1:0] i_reload,
  output logic                   o_tick
);

  typedef struct packed {
    logic [BAUD_W-1:0] cnt;
  } imras_brg_state_type;

  imras_brg_state_type st_r;
  imras_brg_state_type st_nxt;

  // ===================================================================
  // Elaboration check
  initial begin
    if (BAUD_W < 1 || BAUD_W > 16) begin
      $error("imras_brg: BAUD_W must be 1 to 16");
    end
  end

  // Load wins over run, so a restart never emits a stale tick
  assign o_tick = i_run && !i_load && (st_r.cnt == '0);

  // Next count: a period is reload plus one cycles
  always_comb begin
    st_nxt = st_r;
    if (i_load) begin
      st_nxt.cnt = i_reload;
    end else if (i_run) begin
      if (st_r.cnt == '0) begin
        st_nxt.cnt = i_reload;
      end else begin
        st_nxt.cnt = st_r.cnt - 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule

// ### hw/imras_top.sv
`timescale 1ns/1ps
// What this block does
// RULE1: Setting receive enable, control two bit 3, starts a one-byte receive.
// RULE2: Receive enable writes are ignored unless the port is idle.
// RULE3: In receive, SCL toggles each baud rollover; sampled SDA shifts in.
// RULE4: After eighth falling edge, receive enable clears, shift copies to buffer.
// RULE5: Byte done sets interrupt, stops baud, holds SCL low, goes idle.
// RULE6: Buffer full sets when a byte enters buffer, clears on buffer read.
// RULE7: Overflow sets when a byte completes while buffer full is still set.
// RULE8: Buffer write during receive sets write collision, buffer unchanged.
// RULE9: Ack enable, bit 4, pulls SCL low and drives ack data on SDA.
// RULE10: Software clears ack data for ACK, sets it for NACK, beforehand.
// RULE11: Ack sequence counts one baud period, then releases SCL.
// RULE12: Ack high phase timed only after SCL sampled high, then SCL low.
// RULE13: After ack pulse, ack enable clears, baud stops, port goes idle.
// RULE14: Buffer write during ack sets write collision, buffer unchanged.
// RULE15: SCL stays held low after a receive or ack until the next sequence starts; a stop leaves it released.
// RULE16: Stop enable, bit 2, starts a stop sequence by driving SDA low.
// RULE17: Once SDA sampled low in stop, baud reloads and counts to zero.
// RULE18: On stop timeout SCL releases; one baud period later SDA releases.
// RULE19: Stop detected, status bit 4, sets on SDA high while SCL high.
// RULE20: One baud period after stop detect, stop enable clears, irq sets.
// RULE21: Buffer write during stop sets write collision and is ignored.
// RULE22: Every baud reload uses the low seven bits of the baud register.
// RULE23: Software alone clears write collision; hardware never does.
// RULE24: Only one of receive, ack, stop runs at a time, from idle.
module imras_top #(
  parameter int BAUD_W = imras_pkg::BAUD_FIELD_W
) (
  input  wire logic                                I_CLK,
  input  wire logic                                I_RESET,
  input  wire imras_pkg::imras_cmd_type            I_CMD,
  input  wire imras_pkg::imras_sw_type             I_SW,
  input  wire logic [imras_pkg::BYTE_W-1:0]        I_BUF_WDATA,
  input  wire logic [imras_pkg::BAUD_REG_W-1:0]    I_BAUD_REG,
  input  wire logic                                I_SCL_IN,
  input  wire logic                                I_SDA_IN,
  output logic                                     O_SCL_OUT,
  output logic                                     O_SCL_OE_N,
  output logic                                     O_SDA_OUT,
  output logic                                     O_SDA_OE_N,
  output logic [imras_pkg::BYTE_W-1:0]             O_BUF_DATA,
  output imras_pkg::imras_flags_type               O_FLAGS,
  output logic [imras_pkg::CTRL2_W-1:0]            O_CTRL_TWO,
  output logic [imras_pkg::STAT_W-1:0]             O_STATUS
);

  // ===================================================================
  // Elaboration check
  initial begin
    // A reload field wider than the register has no bits to feed it
    if (BAUD_W < 1 || BAUD_W > imras_pkg::BAUD_REG_W) begin
      $error("imras_top: BAUD_W must fit the baud reload register");
    end
  end

  // ===================================================================
  // State carrier
  typedef struct packed {
    imras_pkg::imras_fsm_type               fsm;
    logic                                   scl_s1;
    logic                                   scl_s2;
    logic                                   sda_s1;
    logic                                   sda_s2;
    logic [imras_pkg::BYTE_W-1:0]           shift;
    logic [imras_pkg::BIT_CNT_W-1:0]        bit_cnt;
    logic [imras_pkg::BYTE_W-1:0]           buf_data;
    imras_pkg::imras_flags_type             flags;
    logic                                   rcv_en;
    logic                                   ack_en;
    logic                                   stop_en;
    logic                                   scl_oe_n;
    logic                                   sda_oe_n;
    logic                                   scl_out;
    logic                                   sda_out;
  } imras_state_type;

  imras_state_type              st_r;
  imras_state_type              st_nxt;
  logic                         brg_load;
  logic                         brg_run;
  logic                         brg_tick;
  logic                         busy;
  logic [BAUD_W-1:0]            baud_reload;
  logic [imras_pkg::BYTE_W-1:0] shift_in;

  // ===================================================================
  // Baud rate generator
  // Reload taken from the low bits of the baud register [RULE22]
  assign baud_reload = I_BAUD_REG[BAUD_W-1:0];

  imras_brg #(
    .BAUD_W   (BAUD_W)
  ) u_brg (
    .i_clk    (I_CLK),
    .i_reset  (I_RESET),
    .i_load   (brg_load),
    .i_run    (brg_run),
    .i_reload (baud_reload),
    .o_tick   (brg_tick)
  );

  // Decoded from state, so a write in a start cycle still lands
  // Busy means a sequence owns the bus; starts need idle [RULE2]
  assign busy     = (st_r.fsm != imras_pkg::S_IDLE);
  // Shift value with the freshly sampled bit appended, MSB first
  // Shared by shift and buffer load so both see the same last bit
  assign shift_in = {st_r.shift[imras_pkg::BYTE_W-2:0], st_r.sda_s2};

  // ===================================================================
  // Next state
  always_comb begin
    st_nxt   = st_r;
    brg_load = 1'b0;
    brg_run  = 1'b0;

    // Pins pass two flops; only the second stage is read below
    // Stage one feeds stage two only; it may still be metastable
    st_nxt.scl_s1 = I_SCL_IN;
    st_nxt.scl_s2 = st_r.scl_s1;
    st_nxt.sda_s1 = I_SDA_IN;
    st_nxt.sda_s2 = st_r.sda_s1;

    // Software clears first, so hardware sets below win a tie
    if (I_SW.buf_rd) begin
      st_nxt.flags.buffer_full = 1'b0;                     // [RULE6]
    end
    if (I_SW.ovf_clr) begin
      st_nxt.flags.receive_overflow = 1'b0;
    end
    if (I_SW.write_collision_flag_clr) begin
      st_nxt.flags.write_collision = 1'b0;                 // [RULE23]
    end
    if (I_SW.irq_clr) begin
      st_nxt.flags.serial_irq = 1'b0;
    end

    // Buffer writes are refused while any sequence runs
    if (I_SW.buf_wr) begin
      if (busy) begin
        st_nxt.flags.write_collision = 1'b1;    // [RULE8] [RULE14] [RULE21]
      end else begin
        st_nxt.buf_data = I_BUF_WDATA;
      end
    end

    unique case (st_r.fsm)
      // Idle: SCL keeps whatever the last sequence left [RULE15]
      imras_pkg::S_IDLE: begin
        // Priority receive, ack, stop; losers dropped [RULE24]
        if (I_CMD.rcv_set) begin
          st_nxt.rcv_en              = 1'b1;                 // [RULE1]
          st_nxt.scl_oe_n            = 1'b0;
          st_nxt.sda_oe_n            = 1'b1;
          st_nxt.bit_cnt             = imras_pkg::RST_BIT_CNT;
          st_nxt.flags.stop_detected = 1'b0;
          st_nxt.fsm                 = imras_pkg::S_RX_LOW;
          brg_load                   = 1'b1;
        end else if (I_CMD.ack_set) begin
          // Released SDA sends NACK, driven low sends ACK
          st_nxt.ack_en              = 1'b1;                 // [RULE9]
          st_nxt.scl_oe_n            = 1'b0;
          st_nxt.sda_oe_n            = I_CMD.ack_data;       // [RULE10]
          st_nxt.flags.stop_detected = 1'b0;
          st_nxt.fsm                 = imras_pkg::S_ACK_LOW;
          brg_load                   = 1'b1;
        end else if (I_CMD.stop_set) begin
          st_nxt.stop_en             = 1'b1;
          st_nxt.sda_oe_n            = 1'b0;                 // [RULE16]
          st_nxt.fsm                 = imras_pkg::S_STP_SDA;
        end
      end

      // Receive low phase: rollover releases SCL
      imras_pkg::S_RX_LOW: begin
        brg_run = 1'b1;
        if (brg_tick) begin
          st_nxt.scl_oe_n = 1'b1;                            // [RULE3]
          st_nxt.fsm      = imras_pkg::S_RX_HIGH;
        end
      end

      // Receive high phase: sample at its end, then pull SCL low
      imras_pkg::S_RX_HIGH: begin
        brg_run = 1'b1;
        if (brg_tick) begin
          st_nxt.shift    = shift_in;                        // [RULE3]
          st_nxt.scl_oe_n = 1'b0;
          st_nxt.bit_cnt  = st_r.bit_cnt + 1'b1;
          if (st_r.bit_cnt == imras_pkg::LAST_BIT_IDX) begin
            // A read in this cycle counts as having emptied the buffer
            if (st_nxt.flags.buffer_full) begin
              st_nxt.flags.receive_overflow = 1'b1;          // [RULE7]
            end
            st_nxt.rcv_en            = 1'b0;                 // [RULE4]
            st_nxt.buf_data          = shift_in;             // [RULE4]
            st_nxt.flags.buffer_full = 1'b1;                 // [RULE6]
            st_nxt.flags.serial_irq  = 1'b1;                 // [RULE5]
            st_nxt.fsm               = imras_pkg::S_IDLE;    // [RULE5]
          end else begin
            st_nxt.fsm = imras_pkg::S_RX_LOW;
          end
        end
      end

      // Ack low phase: one period, then release SCL
      imras_pkg::S_ACK_LOW: begin
        brg_run = 1'b1;
        if (brg_tick) begin
          st_nxt.scl_oe_n = 1'b1;                            // [RULE11]
          st_nxt.fsm      = imras_pkg::S_ACK_WAIT;
        end
      end

      // A slave may stretch SCL; timing waits for real high
      // No timeout: a slave that never lets SCL go stalls the port
      imras_pkg::S_ACK_WAIT: begin
        if (st_r.scl_s2) begin
          brg_load   = 1'b1;                                 // [RULE12]
          st_nxt.fsm = imras_pkg::S_ACK_HIGH;
        end
      end

      // Ack high phase: one period, then SCL low and done
      imras_pkg::S_ACK_HIGH: begin
        brg_run = 1'b1;
        if (brg_tick) begin
          st_nxt.scl_oe_n = 1'b0;                            // [RULE12]
          st_nxt.sda_oe_n = 1'b1;
          st_nxt.ack_en   = 1'b0;                            // [RULE13]
          st_nxt.fsm      = imras_pkg::S_IDLE;               // [RULE13]
        end
      end

      // Stop: wait for SDA seen low before timing
      // Waiting on the pin, not a count, copes with a slow fall
      imras_pkg::S_STP_SDA: begin
        if (!st_r.sda_s2) begin
          brg_load   = 1'b1;                                 // [RULE17]
          st_nxt.fsm = imras_pkg::S_STP_LOW;
        end
      end

      // Stop: count down to zero, then release SCL
      imras_pkg::S_STP_LOW: begin
        brg_run = 1'b1;
        if (brg_tick) begin
          st_nxt.scl_oe_n = 1'b1;                            // [RULE18]
          st_nxt.fsm      = imras_pkg::S_STP_SCLH;
        end
      end

      // Stop: one period after SCL release, release SDA
      imras_pkg::S_STP_SCLH: begin
        brg_run = 1'b1;
        if (brg_tick) begin
          st_nxt.sda_oe_n = 1'b1;                            // [RULE18]
          st_nxt.fsm      = imras_pkg::S_STP_DET;
        end
      end

      // Stop: both lines seen high is the stop condition
      // A line held low by another device leaves the stop waiting
      imras_pkg::S_STP_DET: begin
        if (st_r.sda_s2 && st_r.scl_s2) begin
          st_nxt.flags.stop_detected = 1'b1;                 // [RULE19]
          brg_load                   = 1'b1;
          st_nxt.fsm                 = imras_pkg::S_STP_END;
        end
      end

      // Stop: one period later the sequence ends
      imras_pkg::S_STP_END: begin
        brg_run = 1'b1;
        if (brg_tick) begin
          st_nxt.stop_en          = 1'b0;                    // [RULE20]
          st_nxt.flags.serial_irq = 1'b1;                    // [RULE20]
          st_nxt.fsm              = imras_pkg::S_IDLE;
        end
      end

      // Corrupt one-hot code: recover to idle, lines released
      // Enables cleared too, so none reads set without a sequence
      default: begin
        st_nxt.fsm      = imras_pkg::S_IDLE;
        st_nxt.rcv_en   = 1'b0;
        st_nxt.ack_en   = 1'b0;
        st_nxt.stop_en  = 1'b0;
        st_nxt.scl_oe_n = 1'b1;
        st_nxt.sda_oe_n = 1'b1;
      end
    endcase

    // Open-drain pins only ever drive low
    // Only the enables move, so a line never sees a driven high
    st_nxt.scl_out = 1'b0;
    st_nxt.sda_out = 1'b0;
  end

  // ===================================================================
  // State register; lines released and flags clear at reset
  // Synchronisers reset to the idle high level of both lines,
  // so no false edge is seen as reset lifts
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      st_r          <= '0;
      st_r.fsm      <= imras_pkg::S_IDLE;
      st_r.scl_s1   <= 1'b1;
      st_r.scl_s2   <= 1'b1;
      st_r.sda_s1   <= 1'b1;
      st_r.sda_s2   <= 1'b1;
      st_r.shift    <= imras_pkg::RST_BYTE;
      st_r.bit_cnt  <= imras_pkg::RST_BIT_CNT;
      st_r.buf_data <= imras_pkg::RST_BYTE;
      st_r.scl_oe_n <= 1'b1;
      st_r.sda_oe_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ===================================================================
  // Outputs, all straight from state flops
  assign O_SCL_OUT  = st_r.scl_out;
  assign O_SCL_OE_N = st_r.scl_oe_n;
  assign O_SDA_OUT  = st_r.sda_out;
  assign O_SDA_OE_N = st_r.sda_oe_n;
  assign O_BUF_DATA = st_r.buf_data;
  assign O_FLAGS    = st_r.flags;

  // Register images; unlisted bits read as zero
  always_comb begin
    O_CTRL_TWO = '0;
    O_CTRL_TWO[imras_pkg::CTRL2_STOP_EN_BIT] = st_r.stop_en;
    O_CTRL_TWO[imras_pkg::CTRL2_RCV_EN_BIT]  = st_r.rcv_en;
    O_CTRL_TWO[imras_pkg::CTRL2_ACK_EN_BIT]  = st_r.ack_en;
  end

  always_comb begin
    O_STATUS = '0;
    O_STATUS[imras_pkg::STAT_BUF_FULL_BIT] = st_r.flags.buffer_full;
    O_STATUS[imras_pkg::STAT_STOP_DET_BIT] = st_r.flags.stop_detected;
  end

endmodule

// ### testbench/imras_monitor.sv
`timescale 1ns/1ps
// ==========
// Port-level checks of the receive/ack/stop sequencer
module imras_monitor #(
  parameter int BAUD_W = 7
) (
  input wire logic                                I_CLK,
  input wire logic                                I_RESET,
  input wire imras_pkg::imras_cmd_type            I_CMD,
  input wire imras_pkg::imras_sw_type             I_SW,
  input wire logic [imras_pkg::BYTE_W-1:0]        I_BUF_WDATA,
  input wire logic [imras_pkg::BAUD_REG_W-1:0]    I_BAUD_REG,
  input wire logic                                I_SCL_IN,
  input wire logic                                I_SDA_IN,
  input wire logic                                O_SCL_OUT,
  input wire logic                                O_SCL_OE_N,
  input wire logic                                O_SDA_OUT,
  input wire logic                                O_SDA_OE_N,
  input wire logic [imras_pkg::BYTE_W-1:0]        O_BUF_DATA,
  input wire imras_pkg::imras_flags_type          O_FLAGS,
  input wire logic [imras_pkg::CTRL2_W-1:0]       O_CTRL_TWO,
  input wire logic [imras_pkg::STAT_W-1:0]        O_STATUS
);
  logic rcv;
  logic ack;
  logic stp;

  // Enable bits picked out of the control image
  assign rcv = O_CTRL_TWO[imras_pkg::CTRL2_RCV_EN_BIT];
  assign ack = O_CTRL_TWO[imras_pkg::CTRL2_ACK_EN_BIT];
  assign stp = O_CTRL_TWO[imras_pkg::CTRL2_STOP_EN_BIT];

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RESET);

  // ==========
  // Single-cycle pieces
  sequence s_rcv_go;
    $rose(rcv);
  endsequence
  sequence s_sda_up;
    $rose(O_SDA_OE_N) && stp;
  endsequence

  // ==========
  // Properties
  property p_rcv_start;
    s_rcv_go |-> !O_SCL_OE_N && O_SDA_OE_N && !O_FLAGS.stop_detected;
  endproperty
  a_rcv_start: assert property (p_rcv_start) else $error("rx start");
  property p_rcv_done;
    $fell(rcv) |-> O_FLAGS.buffer_full && O_FLAGS.serial_irq && !O_SCL_OE_N;
  endproperty
  a_rcv_done: assert property (p_rcv_done) else $error("rx end");
  property p_scl_held;
    (!O_SCL_OE_N && O_CTRL_TWO[4:2] == 3'h0) |=> !O_SCL_OE_N;
  endproperty
  a_scl_held: assert property (p_scl_held) else $error("scl idle");
  property p_ack_start;
    $rose(ack) |-> !O_SCL_OE_N && (O_SDA_OE_N == $past(I_CMD.ack_data));
  endproperty
  a_ack_start: assert property (p_ack_start) else $error("ack go");
  property p_ack_wait;
    (ack && O_SCL_OE_N && !I_SCL_IN) |=> ack && O_SCL_OE_N;
  endproperty
  a_ack_wait: assert property (p_ack_wait) else $error("ack wait");
  property p_ack_end;
    $fell(ack) |-> !O_SCL_OE_N && O_SDA_OE_N;
  endproperty
  a_ack_end: assert property (p_ack_end) else $error("ack end");
  property p_stop_order;
    s_sda_up |-> O_SCL_OE_N && $past(O_SCL_OE_N);
  endproperty
  a_stop_order: assert property (p_stop_order) else $error("stop");
  property p_stop_det;
    $rose(O_FLAGS.stop_detected) |-> O_STATUS[4] && stp && O_SDA_OE_N;
  endproperty
  a_stop_det: assert property (p_stop_det) else $error("stop det");
  property p_stop_end;
    $fell(stp) |-> O_FLAGS.serial_irq && O_FLAGS.stop_detected;
  endproperty
  a_stop_end: assert property (p_stop_end) else $error("stop end");
  property p_write_collision_flag;
    (I_SW.buf_wr && O_CTRL_TWO[4:2] != 3'h0) |=>
      O_FLAGS.write_collision && ($stable(O_BUF_DATA) || $fell(rcv));
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("write_collision_flag");
  property p_excl;
    $onehot0(O_CTRL_TWO[4:2]);
  endproperty
  a_excl: assert property (p_excl) else $error("two sequences");
endmodule

// ### testbench/imras_slave.sv
`timescale 1ns/1ps
// ==========
// Slave on the bus: sends a byte MSB first, may stretch SCL
module imras_slave (
  input  wire logic       i_clk,
  input  wire logic       i_scl,
  input  wire logic       i_load,
  input  wire logic       i_stretch,
  input  wire logic [7:0] i_tx_byte,
  output logic            o_scl_rel,
  output logic            o_sda_rel
);
  logic [3:0] idx_r = 4'h8;
  logic       scl_d_r = 1'b1;

  // Next bit after each SCL fall, so data is stable while SCL is high
  always @(posedge i_clk) begin
    scl_d_r <= i_scl;
    if (i_load) begin
      idx_r <= 4'h0;
    end else if (scl_d_r && !i_scl && idx_r < 4'h8) begin
      idx_r <= idx_r + 4'h1;
    end
  end

  // Released lines float to the pull-up level
  assign o_sda_rel = (idx_r < 4'h8) ? i_tx_byte[3'h7 - idx_r[2:0]] : 1'b1;
  assign o_scl_rel = !i_stretch;
endmodule

// ### testbench/tb_top.sv
`timescale 1ns/1ps
// ==========
// Self-checking bench
module tb_top;
  logic                       clk, rst, load, stretch, scl_o, sda_o;
  logic                       scl_rel, sda_rel, scl_oe_n, sda_oe_n;
  logic [7:0]                 wdata, baud, tx, buf_data, ctrl, stat, bexp;
  imras_pkg::imras_cmd_type   cmd;
  imras_pkg::imras_sw_type    sw;
  imras_pkg::imras_flags_type flags;
  int                         err_count, n_tests, seed, p, r, k;
  logic [7:0]                 exp_q[$];
  wire                        scl = scl_oe_n & scl_rel;
  wire                        sda = sda_oe_n & sda_rel;

  imras_top imras_top_i (.I_CLK(clk), .I_RESET(rst), .I_CMD(cmd), .I_SW(sw),
    .I_BUF_WDATA(wdata), .I_BAUD_REG(baud), .I_SCL_IN(scl), .I_SDA_IN(sda),
    .O_SCL_OUT(scl_o), .O_SCL_OE_N(scl_oe_n), .O_SDA_OUT(sda_o),
    .O_SDA_OE_N(sda_oe_n),
    .O_BUF_DATA(buf_data), .O_FLAGS(flags), .O_CTRL_TWO(ctrl),
    .O_STATUS(stat));
  imras_slave imras_slave_i (.i_clk(clk), .i_scl(scl), .i_load(load),
    .i_stretch(stretch), .i_tx_byte(tx), .o_scl_rel(scl_rel),
    .o_sda_rel(sda_rel));

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ==========
  // Helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("mismatches=%0d comparisons=%0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  function automatic logic cur(input int s);
    return (s < 8) ? ctrl[s] : (s == 8) ? scl_oe_n : flags.stop_detected;
  endfunction
  // Bounded wait, counting falling edges; a hang is a mismatch
  task automatic wait_on(input int s, input logic v, output int n);
    n = 0;
    while (cur(s) !== v && n < 4000) begin
      @(negedge clk);
      n++;
    end
    if (n == 4000) chk(8'h01, 8'h00);
  endtask
  task automatic go(input logic [3:0] c);
    cmd = c;
    @(negedge clk);
    cmd = {3'b000, c[0]};
  endtask
  task automatic swp(input logic [4:0] s);
    sw = s;
    @(negedge clk);
    sw = '0;
  endtask
  // One received byte, with a refused write and refused commands inside
  task automatic rx(input logic [7:0] b);
    tx = b;
    exp_q.push_back(b);
    go(4'h8);
    load = 1'b1;
    repeat (2) @(negedge clk);
    load = 1'b0;
    wait_on(3, 1'b1, k);
    wait_on(8, 1'b1, k);
    wait_on(8, 1'b0, k);
    chk(8'(k), 8'(p));
    wdata = 8'($random(seed));
    swp(5'h10);
    chk(8'({flags.write_collision, buf_data == bexp}), 8'h03);
    go(4'hC);
    chk(8'(ctrl[4:3]), 8'h01);
    wait_on(3, 1'b0, k);
    bexp = b;
    chk(8'({flags.serial_irq, flags.buffer_full, scl_oe_n}), 8'h06);
    repeat (3 * p) @(negedge clk);
    chk(8'(scl_oe_n), 8'h00);
  endtask

  // Received bytes compared in order of arrival
  initial forever begin
    @(negedge ctrl[3]);
    @(negedge clk);
    if (exp_q.size() > 0) chk(buf_data, exp_q.pop_front());
  end

  // Watchdog, far beyond the few hundred cycles needed
  initial begin
    #(50 * 30000);
    err_count++;
    end_sim();
  end

  // ==========
  // Main sequence
  initial begin
    seed = 32'hb002dda8;
    {err_count, n_tests, rst, load, stretch} = '0;
    rst = 1'b1;
    cmd = '0;
    sw = '0;
    {wdata, tx, bexp} = '0;
    baud = 8'h83;
    p = 4;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    chk(ctrl, 8'h00);
    chk(stat, 8'h00);
    chk(8'({flags, scl_oe_n, sda_oe_n}), 8'h03);
    chk(8'({scl_o, sda_o}), 8'h00);
    // Two bytes unread: the second overflows; top baud bit is ignored
    for (int i = 0; i < 2; i++) begin
      r = 3 + ($random(seed) & 3);
      p = r + 1;
      baud = 8'h80 | 8'(r);
      rx(8'($random(seed)));
      chk(8'(flags.receive_overflow), 8'(i));
    end
    swp(5'h08);
    chk(8'(flags.buffer_full), 8'h00);
    chk(8'(flags[3:1]), 8'h07);
    @(negedge clk);
    swp(5'h07);
    chk(8'(flags[3:1]), 8'h00);
    // ACK then NACK, the slave holding SCL low before the high phase
    for (int d = 0; d < 2; d++) begin
      stretch = 1'b1;
      go({3'b010, d[0]});
      wait_on(4, 1'b1, k);
      chk(8'({scl_oe_n, sda_oe_n}), 8'(d));
      swp(5'h10);
      chk(8'({flags.write_collision, buf_data == bexp}), 8'h03);
      wait_on(8, 1'b1, k);
      repeat (6) @(negedge clk);
      chk(8'({ctrl[4], scl_oe_n}), 8'h03);
      stretch = 1'b0;
      wait_on(4, 1'b0, k);
      chk(8'(k >= p + 1 && k <= p + 4), 8'h01);
      chk(8'({scl_oe_n, sda_oe_n, flags.serial_irq}), 8'h02);
      swp(5'h04);
    end
    // Stop with a refused buffer write
    go(4'h2);
    wait_on(2, 1'b1, k);
    chk(8'(sda_oe_n), 8'h00);
    chk(8'({scl_o, sda_o}), 8'h00);
    swp(5'h10);
    chk(8'({flags.write_collision, buf_data == bexp}), 8'h03);
    wait_on(9, 1'b1, k);
    chk(8'(k), 8'(2 * p + 5));
    chk(8'({stat[4], scl_oe_n, sda_oe_n, flags.serial_irq}), 8'h0E);
    wait_on(2, 1'b0, k);
    chk(8'(k), 8'(p));
    chk(8'(flags.serial_irq), 8'h01);
    end_sim();
  end
endmodule

bind imras_top imras_monitor #(.BAUD_W(BAUD_W)) imras_monitor_i (
  .I_CLK(I_CLK), .I_RESET(I_RESET), .I_CMD(I_CMD), .I_SW(I_SW),
  .I_BUF_WDATA(I_BUF_WDATA), .I_BAUD_REG(I_BAUD_REG), .I_SCL_IN(I_SCL_IN),
  .I_SDA_IN(I_SDA_IN), .O_SCL_OUT(O_SCL_OUT), .O_SCL_OE_N(O_SCL_OE_N),
  .O_SDA_OUT(O_SDA_OUT), .O_SDA_OE_N(O_SDA_OE_N), .O_BUF_DATA(O_BUF_DATA),
  .O_FLAGS(O_FLAGS), .O_CTRL_TWO(O_CTRL_TWO), .O_STATUS(O_STATUS));
